// ### hdl/vslm_pkg.sv
// Constants and carrier types for the signal and location monitor block
package vslm_pkg;
   localparam logic [15:0] VSLM_OFS_COMMAND = 16'h1000;
   localparam logic [15:0] VSLM_OFS_STATUS = 16'h1001;
   localparam logic [15:0] VSLM_OFS_BASE_HIGH = 16'h1002;
   localparam logic [15:0] VSLM_OFS_BASE_LOW = 16'h1003;
   // Command bit positions
   localparam int VSLM_SET_SOFT1_BIT = 7;
   localparam int VSLM_SET_SOFT0_BIT = 6;
   localparam int VSLM_SET_MON1_BIT = 5;
   localparam int VSLM_SET_MON0_BIT = 4;
   localparam int VSLM_CLR_SOFT1_BIT = 3;
   localparam int VSLM_CLR_SOFT0_BIT = 2;
   localparam int VSLM_CLR_MON1_BIT = 1;
   localparam int VSLM_CLR_MON0_BIT = 0;
   // Status and base-low field positions
   localparam int VSLM_ENABLE_LSB = 4;
   localparam int VSLM_MON_ENABLE_BIT = 3;
   // Monitor offsets within the 16-byte window
   localparam logic [3:0] VSLM_MON1_OFFSET = 4'h3;
   localparam logic [3:0] VSLM_MON0_OFFSET = 4'h1;
   // Reset values
   localparam logic [3:0] VSLM_FLAGS_RESET = 4'h0;
   localparam logic [3:0] VSLM_ENABLES_RESET = 4'h0;
   localparam logic [7:0] VSLM_BASE_HIGH_RESET = 8'h00;
   localparam logic [3:0] VSLM_BASE_LOW_RESET = 4'h0;

   // Flags, order {soft_flag_1, soft_flag_0, monitor_flag_1, monitor_flag_0}
   typedef struct packed {
      logic [3:0] flags;
      logic [3:0] enables;
      logic [7:0] base_high;
      logic [3:0] base_low;
      logic mon_enable;
   } vslm_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } vslm_io_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } vslm_vme_access_t;
endpackage : vslm_pkg

// ### hdl/vslm_match.sv
// Location monitor address comparator
`timescale 1ns/1ns
module vslm_match import vslm_pkg::*; (
   // Programmed window
   input wire logic mon_enable,
   input wire logic [7:0] base_high,
   input wire logic [3:0] base_low,
   // Observed access
   input wire vslm_vme_access_t access,
   // Hits
   output logic hit_1,
   output logic hit_0
);
   logic window_hit;

   always_comb begin
      window_hit = mon_enable && access.valid && (access.addr[15:4] == {base_high, base_low});
      hit_1 = window_hit && (access.addr[3:0] == VSLM_MON1_OFFSET);
      hit_0 = window_hit && (access.addr[3:0] == VSLM_MON0_OFFSET);
   end
endmodule : vslm_match

// ### hdl/vslm_irq.sv
// Interrupt combiner for the two signal/monitor interrupt lines
`timescale 1ns/1ns
module vslm_irq import vslm_pkg::*; (
   // Flags and enables
   input wire logic [3:0] flags,
   input wire logic [3:0] enables,
   // Interrupt lines
   output logic irq_1,
   output logic irq_0
);
   logic [3:0] active;

   always_comb begin
      active = flags & enables;
      irq_1 = active[3] | active[1];
      irq_0 = active[2] | active[0];
   end
endmodule : vslm_irq

// ### hdl/vslm_top.sv
// Signal flags, location monitor and their register block
`timescale 1ns/1ns
module vslm_top import vslm_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Local and bridged byte I/O port
   input wire vslm_io_req_t io_req,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   // Observed VMEbus accesses for the location monitor
   input wire vslm_vme_access_t vme_access,
   // Interrupts to the processors
   output logic irq_1,
   output logic irq_0
);
   vslm_state_t st_r;
   vslm_state_t st_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rvalid_r;
   logic hit_1;
   logic hit_0;
   logic [3:0] set_vec;
   logic [3:0] clr_vec;
   logic cmd_wr;

   vslm_match u_match (
      .mon_enable(st_r.mon_enable),
      .base_high(st_r.base_high),
      .base_low(st_r.base_low),
      .access(vme_access),
      .hit_1(hit_1),
      .hit_0(hit_0)
   );

   vslm_irq u_irq (
      .flags(st_r.flags),
      .enables(st_r.enables),
      .irq_1(irq_1),
      .irq_0(irq_0)
   );

   always_comb begin
      st_nxt = st_r;
      rdata_nxt = 8'h00;
      cmd_wr = io_req.wr && (io_req.addr == VSLM_OFS_COMMAND);
      set_vec = 4'h0;
      clr_vec = 4'h0;
      if (cmd_wr) begin
         set_vec = {io_req.wdata[VSLM_SET_SOFT1_BIT], io_req.wdata[VSLM_SET_SOFT0_BIT],
                    io_req.wdata[VSLM_SET_MON1_BIT], io_req.wdata[VSLM_SET_MON0_BIT]};
         clr_vec = {io_req.wdata[VSLM_CLR_SOFT1_BIT], io_req.wdata[VSLM_CLR_SOFT0_BIT],
                    io_req.wdata[VSLM_CLR_MON1_BIT], io_req.wdata[VSLM_CLR_MON0_BIT]};
      end
      // Clear wins over a set bit in the same write; a bus hit in that cycle still lands,
      // so software never loses an access that arrived while it was clearing the flag
      st_nxt.flags = ((st_r.flags | set_vec) & ~clr_vec) | {2'b00, hit_1, hit_0};
      if (io_req.wr) begin
         case (io_req.addr)
            VSLM_OFS_STATUS: st_nxt.enables = io_req.wdata[7:VSLM_ENABLE_LSB];
            VSLM_OFS_BASE_HIGH: st_nxt.base_high = io_req.wdata;
            VSLM_OFS_BASE_LOW: begin
               st_nxt.base_low = io_req.wdata[7:4];
               st_nxt.mon_enable = io_req.wdata[VSLM_MON_ENABLE_BIT];
            end
            default: ;
         endcase
      end
      if (io_req.rd) begin
         case (io_req.addr)
            VSLM_OFS_COMMAND: rdata_nxt = 8'h00;
            VSLM_OFS_STATUS: rdata_nxt = {st_r.enables, st_r.flags};
            VSLM_OFS_BASE_HIGH: rdata_nxt = st_r.base_high;
            VSLM_OFS_BASE_LOW: rdata_nxt = {st_r.base_low, st_r.mon_enable, 3'h0};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{flags: VSLM_FLAGS_RESET, enables: VSLM_ENABLES_RESET,
                   base_high: VSLM_BASE_HIGH_RESET, base_low: VSLM_BASE_LOW_RESET, mon_enable: 1'b0};
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= io_req.rd;
      end
   end

   assign io_rdata = rdata_r;
   assign io_rvalid = rvalid_r;

   // Checks
   chk_cmd_set_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (io_req.wr && io_req.addr == VSLM_OFS_COMMAND && io_req.wdata[7] && !io_req.wdata[3])
      |=> st_r.flags[3]) else $error("soft flag 1 not set");
   chk_cmd_clr_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (io_req.wr && io_req.addr == VSLM_OFS_COMMAND && io_req.wdata[1] && !hit_1)
      |=> !st_r.flags[1]) else $error("monitor flag 1 not cleared");
   chk_clear_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (io_req.wr && io_req.addr == VSLM_OFS_COMMAND && io_req.wdata[6] && io_req.wdata[2])
      |=> !st_r.flags[2]) else $error("clear did not win");
   chk_soft_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !(io_req.wr && io_req.addr == VSLM_OFS_COMMAND) |=> st_r.flags[3:2] == $past(st_r.flags[3:2]))
      else $error("soft flag changed without command");
   chk_mon_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (st_r.flags[0] && !(io_req.wr && io_req.addr == VSLM_OFS_COMMAND && io_req.wdata[0]))
      |=> st_r.flags[0]) else $error("monitor flag 0 dropped");
   chk_hit_sets_lm1: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (vme_access.valid && st_r.mon_enable && vme_access.addr == {st_r.base_high, st_r.base_low, 4'h3})
      |=> st_r.flags[1]) else $error("monitor hit at offset 3 lost");
   chk_no_hit_disabled: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !st_r.mon_enable |-> !hit_0 && !hit_1) else $error("hit while monitor disabled");
   chk_irq_one_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
      irq_1 == ((st_r.flags[3] && st_r.enables[3]) || (st_r.flags[1] && st_r.enables[1])))
      else $error("interrupt 1 mismatch");
   chk_irq_zero_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
      irq_0 == ((st_r.flags[2] && st_r.enables[2]) || (st_r.flags[0] && st_r.enables[0])))
      else $error("interrupt 0 mismatch");
   chk_status_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (io_req.rd && io_req.addr == VSLM_OFS_STATUS) |=> io_rvalid && io_rdata == $past({st_r.enables, st_r.flags}))
      else $error("status read wrong");
   chk_command_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (io_req.rd && io_req.addr == VSLM_OFS_COMMAND) |=> io_rdata == 8'h00)
      else $error("command register read not zero");
endmodule : vslm_top

// ### verification/vslm_vme_model.sv
// Far-side model: a VMEbus master whose accesses the location monitor observes
`timescale 1ns/1ns
module vslm_vme_model import vslm_pkg::*; (
   // Clock
   input wire logic ref_clk,
   // Observed access
   output vslm_vme_access_t vme_access
);
   initial vme_access = '{1'b0, 16'hFFFF};
   // Each access is driven straight onto vme_access for one clock
   // Released address shows its inverse so a stale value never looks like a hit
   task hit(input logic [15:0] a);
      vme_access <= '{1'b1, a};
      @(posedge ref_clk);
      vme_access <= '{1'b0, ~a};
   endtask : hit
endmodule : vslm_vme_model

// ### verification/vme_signal_location_monitor_tb_top.sv
// Self-checking bench for the signal and location monitor block
`timescale 1ns/1ns
module vme_signal_location_monitor_tb_top import vslm_pkg::*;;
   typedef struct packed {logic [1:0] k; logic [15:0] a; logic [7:0] d; logic [7:0] r; logic [1:0] i;} vslm_row_t;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   vslm_io_req_t io_req = '0;
   vslm_vme_access_t vme_access;
   logic [7:0] io_rdata;
   logic io_rvalid, irq_1, irq_0;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   // Kind 0 write, 1 read, 2 monitored access; i is {irq_1, irq_0}
   vslm_row_t rows [30] = '{
      '{2'h0, 16'h1002, 8'h12, 8'h00, 2'h0}, '{2'h1, 16'h1002, 8'h00, 8'h12, 2'h0},
      '{2'h0, 16'h1003, 8'hAF, 8'h00, 2'h0}, '{2'h1, 16'h1003, 8'h00, 8'hA8, 2'h0},
      '{2'h1, 16'h1000, 8'h00, 8'h00, 2'h0},
      '{2'h0, 16'h1001, 8'hFF, 8'h00, 2'h0}, '{2'h1, 16'h1001, 8'h00, 8'hF0, 2'h0},
      '{2'h0, 16'h1000, 8'h80, 8'h00, 2'h2},
      '{2'h0, 16'h1000, 8'h40, 8'h00, 2'h3},
      '{2'h0, 16'h1000, 8'hC0, 8'h00, 2'h3},
      '{2'h0, 16'h1000, 8'h88, 8'h00, 2'h1},
      '{2'h1, 16'h1001, 8'h00, 8'hF4, 2'h1},
      '{2'h2, 16'h12A3, 8'h00, 8'h00, 2'h3},
      '{2'h2, 16'h12A1, 8'h00, 8'h00, 2'h3},
      '{2'h1, 16'h1001, 8'h00, 8'hF7, 2'h3},
      '{2'h0, 16'h1000, 8'h07, 8'h00, 2'h0},
      '{2'h2, 16'h12A2, 8'h00, 8'h00, 2'h0}, '{2'h2, 16'h13A3, 8'h00, 8'h00, 2'h0},
      '{2'h0, 16'h1001, 8'h00, 8'h00, 2'h0},
      '{2'h0, 16'h1000, 8'h30, 8'h00, 2'h0}, '{2'h1, 16'h1001, 8'h00, 8'h03, 2'h0},
      '{2'h0, 16'h1001, 8'h20, 8'h00, 2'h2},
      '{2'h0, 16'h1001, 8'h10, 8'h00, 2'h1},
      '{2'h0, 16'h1001, 8'hC0, 8'h00, 2'h0},
      '{2'h0, 16'h1000, 8'h03, 8'h00, 2'h0}, '{2'h0, 16'h1003, 8'hA0, 8'h00, 2'h0},
      '{2'h2, 16'h12A3, 8'h00, 8'h00, 2'h0}, '{2'h1, 16'h1001, 8'h00, 8'hC0, 2'h0},
      '{2'h0, 16'h1004, 8'hFF, 8'h00, 2'h0}, '{2'h1, 16'h1004, 8'h00, 8'h00, 2'h0}
   };

   vslm_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .io_req(io_req), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid), .vme_access(vme_access), .irq_1(irq_1), .irq_0(irq_0));
   vslm_vme_model u_vme (.ref_clk(ref_clk), .vme_access(vme_access));

   always #5 ref_clk = ~ref_clk;

   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   task chk(input logic [10:0] got, input logic [10:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One transfer, then outputs of the taking edge are compared
   task step(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d, input logic [7:0] r,
      input logic [1:0] i);
      @(posedge ref_clk);
      io_req <= '{k == 2'h0, k == 2'h1, a, d};
      if (k == 2'h2) u_vme.hit(a);
      else @(posedge ref_clk);
      io_req <= '{1'b0, 1'b0, ~a, ~d};
      #1 chk({io_rdata, io_rvalid, irq_1, irq_0}, {r, k == 2'h1, i});
   endtask : step

   // Hang guard, far above the roughly one hundred cycles the run needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         report_and_stop;
      end
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      foreach (rows[n]) begin
         step(rows[n].k, rows[n].a, rows[n].d, rows[n].r, rows[n].i);
         $display("row %0d done", n);
      end
      step(2'h0, 16'h1003, 8'hA8, 8'h00, 2'h0);
      step(2'h0, 16'h1001, 8'hFF, 8'h00, 2'h0);
      @(posedge ref_clk);
      io_req <= '{1'b1, 1'b0, 16'h1000, 8'h02};
      u_vme.hit(16'h12A3);
      io_req <= '0;
      step(2'h1, 16'h1001, 8'h00, 8'hF2, 2'h2);
      $display("clear against hit done");
      step(2'h0, 16'h1000, 8'h80, 8'h00, 2'h2);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 chk({io_rdata, io_rvalid, irq_1, irq_0}, 11'h000);
      @(posedge ref_clk);
      rst_b <= 1'b1;
      step(2'h1, 16'h1001, 8'h00, 8'h00, 2'h0);
      step(2'h1, 16'h1002, 8'h00, 8'h00, 2'h0);
      step(2'h1, 16'h1003, 8'h00, 8'h00, 2'h0);
      $display("reset test done");
      report_and_stop;
   end
endmodule : vme_signal_location_monitor_tb_top
